// *** pps_pkg.sv ***
// package for the pwm protection supervisor: timing counts and carrier structs
package pps_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIG_FAST_US = 110;
  localparam int TRIG_SLOW_MS = 10;
  localparam int FB_HIGH_MS = 50;
  localparam int TOFF_BLANK_NS = 1500;
  localparam int TRIG_FAST_CYC = (TRIG_FAST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_SLOW_CYC = (TRIG_SLOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FB_HIGH_CYC = (FB_HIGH_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_BLANK_CYC = (TOFF_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ---------------------------------------------------------------
  // supervisor states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PPS_ST_OFF = 2'b00,
    PPS_ST_RUN = 2'b01,
    PPS_ST_PROT = 2'b11
  } pps_state_e;

  // ---------------------------------------------------------------
  // comparator flags from the analog front end
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_on_thr;
    logic supply_off_thr;
    logic overvoltage_guard;
    logic trig_below_0v8;
    logic trig_below_0v5;
    logic aux_above_2v5;
    logic fb_above_4v2;
  } pps_flags_s;

  // ---------------------------------------------------------------
  // enables and status towards the gate logic
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pfc_enable;
    logic pwm_enable;
    logic startup_src_on;
    logic protect_active;
  } pps_ctrl_s;

endpackage : pps_pkg

// *** pps_supervisor.sv ***
// protection supervisor gating pfc and pwm switching
`timescale 1ns/10ps
module pps_supervisor #(
  parameter int TRIG_FAST_CNT = pps_pkg::TRIG_FAST_CYC,
  parameter int TRIG_SLOW_CNT = pps_pkg::TRIG_SLOW_CYC,
  parameter int FB_HIGH_CNT = pps_pkg::FB_HIGH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // comparator flags and switching state
  input wire pps_pkg::pps_flags_s flags,
  input wire logic pwm_gate_on,
  // control outputs
  output pps_pkg::pps_ctrl_s ctrl,
  output logic fault_fb,
  output logic fault_trig,
  output logic fault_out_ovp
);
  import pps_pkg::*;

  // ---------------------------------------------------------------
  // debounce timers
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] trig_cnt_reg, trig_cnt_next;
  logic [CNT_W-1:0] fb_cnt_reg, fb_cnt_next;
  logic trig_trip, fb_trip;

  always_comb begin
    trig_cnt_next = '0;
    trig_trip = 1'b0;
    // timer only runs while the trigger input stays low
    if (flags.trig_below_0v8) begin
      if (flags.trig_below_0v5) begin
        trig_trip = trig_cnt_reg >= CNT_W'(TRIG_FAST_CNT - 1);
      end else begin
        trig_trip = trig_cnt_reg >= CNT_W'(TRIG_SLOW_CNT - 1);
      end
      trig_cnt_next = trig_trip ? trig_cnt_reg : trig_cnt_reg + 1'b1;
    end // else cleared
    fb_cnt_next = '0;
    fb_trip = 1'b0;
    if (flags.fb_above_4v2) begin
      fb_trip = fb_cnt_reg >= CNT_W'(FB_HIGH_CNT - 1);
      fb_cnt_next = fb_trip ? fb_cnt_reg : fb_cnt_reg + 1'b1;
    end // else cleared
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_cnt_reg <= '0;
      fb_cnt_reg <= '0;
    end else begin
      trig_cnt_reg <= trig_cnt_next;
      fb_cnt_reg <= fb_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // off-time blanking and plateau sampling
  // ---------------------------------------------------------------
  logic [7:0] blank_cnt_reg, blank_cnt_next;
  logic sampled_reg, sampled_next;
  logic ovp_trip;

  always_comb begin
    blank_cnt_next = '0;
    sampled_next = 1'b0;
    ovp_trip = 1'b0;
    // new switching cycle rearms the sample
    if (!pwm_gate_on && ctrl.pwm_enable) begin
      sampled_next = sampled_reg;
      if (blank_cnt_reg < 8'(TOFF_BLANK_CYC)) begin
        blank_cnt_next = blank_cnt_reg + 8'h01;
      end else begin
        blank_cnt_next = blank_cnt_reg;
        if (!sampled_reg) begin
          sampled_next = 1'b1;
          ovp_trip = flags.aux_above_2v5;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blank_cnt_reg <= '0;
      sampled_reg <= 1'b0;
    end else begin
      blank_cnt_reg <= blank_cnt_next;
      sampled_reg <= sampled_next;
    end
  end

  // ---------------------------------------------------------------
  // supply lockout and auto-recovery state
  // ---------------------------------------------------------------
  pps_state_e state_reg, state_next;
  pps_ctrl_s ctrl_next;
  logic fault_fb_next, fault_trig_next, fault_ovp_next;
  logic any_fault;

  always_comb begin
    any_fault = flags.overvoltage_guard || trig_trip || fb_trip || ovp_trip;
    state_next = state_reg;
    fault_fb_next = fault_fb;
    fault_trig_next = fault_trig;
    fault_ovp_next = fault_out_ovp;
    unique case (state_reg)
      PPS_ST_OFF: begin
        // hysteresis between 18 V start and 10 V stop
        if (flags.supply_on_thr && !any_fault) begin
          state_next = PPS_ST_RUN;
          fault_fb_next = 1'b0;
          fault_trig_next = 1'b0;
          fault_ovp_next = 1'b0;
        end
      end
      PPS_ST_RUN: begin
        if (any_fault) begin
          state_next = PPS_ST_PROT;
        end else if (!flags.supply_off_thr) begin
          state_next = PPS_ST_OFF;
        end
      end
      PPS_ST_PROT: begin
        // hold off until supply drops below stop level
        if (!flags.supply_off_thr) begin
          state_next = PPS_ST_OFF;
        end
      end
      // unused code 2'b10 falls back to lockout
      default: begin
        state_next = PPS_ST_OFF;
      end
    endcase
    if (fb_trip) begin
      fault_fb_next = 1'b1;
    end
    if (trig_trip) begin
      fault_trig_next = 1'b1;
    end
    if (ovp_trip) begin
      fault_ovp_next = 1'b1;
    end
    ctrl_next.pfc_enable = (state_next == PPS_ST_RUN);
    ctrl_next.pwm_enable = (state_next == PPS_ST_RUN);
    ctrl_next.startup_src_on = (state_next == PPS_ST_OFF);
    ctrl_next.protect_active = (state_next == PPS_ST_PROT);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PPS_ST_OFF;
      ctrl <= '{pfc_enable: 1'b0, pwm_enable: 1'b0, startup_src_on: 1'b1, protect_active: 1'b0};
      fault_fb <= 1'b0;
      fault_trig <= 1'b0;
      fault_out_ovp <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl <= ctrl_next;
      fault_fb <= fault_fb_next;
      fault_trig <= fault_trig_next;
      fault_out_ovp <= fault_ovp_next;
    end
  end

endmodule : pps_supervisor

// *** pps_supervisor_asserts.sv ***
// checker for the protection supervisor ports
`timescale 1ns/10ps
module pps_supervisor_asserts #(
  parameter int TRIG_FAST_CNT = 8,
  parameter int TRIG_SLOW_CNT = 20,
  parameter int FB_HIGH_CNT = 30
) (
  // watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire pps_pkg::pps_flags_s flags,
  input wire logic pwm_gate_on,
  input wire pps_pkg::pps_ctrl_s ctrl,
  input wire logic fault_fb,
  input wire logic fault_trig,
  input wire logic fault_out_ovp
);
  import pps_pkg::*;
  int lo_reg, lo_next, fb_reg, fb_next, off_reg, off_next;
  // ----
  // run lengths of trigger low, feedback high and gate off
  // ----
  always_comb begin
    lo_next = flags.trig_below_0v8 ? lo_reg + 1 : 0;
    fb_next = flags.fb_above_4v2 ? fb_reg + 1 : 0;
    off_next = pwm_gate_on ? 0 : off_reg + 1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_reg <= 0;
      fb_reg <= 0;
      off_reg <= 0;
    end else begin
      lo_reg <= lo_next;
      fb_reg <= fb_next;
      off_reg <= off_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    !ctrl.pwm_enable && !ctrl.protect_active ##1 ctrl.pwm_enable;
  endsequence
  AST_START: assert property (s_start |-> $past(flags.supply_on_thr) && ctrl.pfc_enable && !ctrl.startup_src_on)
    else $error("bad start");
  AST_OVP: assert property (flags.overvoltage_guard && ctrl.pwm_enable |=> ctrl.protect_active && !ctrl.pfc_enable)
    else $error("supply ovp not acted on");
  AST_LOCKOUT: assert property (!flags.supply_off_thr |=> !ctrl.pwm_enable && !ctrl.pfc_enable)
    else $error("running below stop level");
  AST_RECOVER: assert property ($fell(ctrl.protect_active) |-> !$past(flags.supply_off_thr) && ctrl.startup_src_on)
    else $error("early recovery");
  AST_TRIG_MIN: assert property ($rose(fault_trig) |-> lo_reg >= TRIG_FAST_CNT - 2)
    else $error("trigger trip too early");
  AST_TRIG_SLOW: assert property ($rose(fault_trig) && !$past(flags.trig_below_0v5) |-> lo_reg >= TRIG_SLOW_CNT - 2)
    else $error("slow trip too early");
  AST_TRIG_MAX: assert property (flags.trig_below_0v5 && lo_reg == TRIG_FAST_CNT + 2 |-> fault_trig)
    else $error("fast trip missing");
  AST_FB_MIN: assert property ($rose(fault_fb) |-> fb_reg >= FB_HIGH_CNT - 2)
    else $error("feedback trip too early");
  AST_FB_MAX: assert property (fb_reg == FB_HIGH_CNT + 2 |-> fault_fb)
    else $error("feedback trip missing");
  AST_BLANK: assert property ($rose(fault_out_ovp) |-> off_reg >= TOFF_BLANK_CYC - 2)
    else $error("aux sampled inside blanking");
endmodule : pps_supervisor_asserts
bind pps_supervisor pps_supervisor_asserts #(.TRIG_FAST_CNT(TRIG_FAST_CNT), .TRIG_SLOW_CNT(TRIG_SLOW_CNT),
  .FB_HIGH_CNT(FB_HIGH_CNT)) u_chk (.clk(clk), .rst_b(rst_b), .flags(flags), .pwm_gate_on(pwm_gate_on),
  .ctrl(ctrl), .fault_fb(fault_fb), .fault_trig(fault_trig), .fault_out_ovp(fault_out_ovp));

// *** pps_plant.sv ***
// gate driver model: 30 cycles on, 170 off while enabled
`timescale 1ns/10ps
module pps_plant (
  // gate side
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  output logic gate
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= (!en || cnt_reg == 8'hc7) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
  assign gate = en && cnt_reg < 8'h1e;
endmodule : pps_plant

// *** testbench.sv ***
// self-checking bench for the protection supervisor
`timescale 1ns/10ps
module testbench;
  import pps_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic gate, fault_fb, fault_trig, fault_out_ovp;
  pps_flags_s flags = '0;
  pps_ctrl_s ctrl;
  int n_fail = 0, comparisons = 0, cyc = 0;
  logic [2:0] exp_q[$];
  always #5 clk = ~clk;
  pps_supervisor #(.TRIG_FAST_CNT(8), .TRIG_SLOW_CNT(20), .FB_HIGH_CNT(30)) dut (.clk(clk), .rst_b(rst_b),
    .flags(flags), .pwm_gate_on(gate), .ctrl(ctrl), .fault_fb(fault_fb), .fault_trig(fault_trig),
    .fault_out_ovp(fault_out_ovp));
  pps_plant plant (.clk(clk), .rst_b(rst_b), .en(ctrl.pwm_enable), .gate(gate));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task automatic scen(input logic [6:0] v, input logic [2:0] f, input int pre, input int post);
    flags = 7'b1100000;
    cy(2);
    chk(4'b1100, ctrl);
    flags = v;
    exp_q.push_back(f);
    cy(pre);
    chk(4'b1100, ctrl);
    cy(post);
    chk(4'b0001, ctrl);
    flags = 7'b0000000;
    cy(2);
    chk(4'b0010, ctrl);
  endtask : scen
  // cause flags at each entry into protection
  always @(posedge ctrl.protect_active) begin
    #2;
    chk({1'b0, exp_q.pop_front()}, {1'b0, fault_fb, fault_trig, fault_out_ovp});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h0b3b8013));
    cy(8);
    rst_b = 1'b1;
    scen(7'b0110000, 3'b000, 0, 2);
    flags = 7'b1100000;
    cy(2);
    repeat (6) begin
      flags = 7'b0101100;
      cy($urandom_range(6, 1));
      flags = 7'b0100000;
      cy(1);
    end
    chk(4'b1100, ctrl);
    scen(7'b0101100, 3'b010, 5, 6);
    scen(7'b0101000, 3'b010, 12, 12);
    scen(7'b0100001, 3'b100, 25, 10);
    scen(7'b0100010, 3'b001, 100, 120);
    flags = 7'b1100000;
    cy(2);
    chk(4'b1100, ctrl);
    flags = 7'b0100000;
    cy(2);
    chk(4'b1100, ctrl);
    flags = 7'b0000000;
    cy(2);
    chk(4'b0010, ctrl);
    flags = 7'b0001100;
    cy(12);
    flags = 7'b1101100;
    cy(3);
    chk(4'b0010, ctrl);
    chk(4'h0, 4'(exp_q.size()));
    end_sim();
  end
endmodule : testbench
